/* rtl/ards_regs.sv */
`timescale 1ns/10ps

// Summary of operation
// - with hold-off clear, an alarm bit stays set until the status has been read, whether or not its condition is gone.
// - with hold-off set, an alarm bit clears as soon as its condition subsides, read or not.
// - routing bits 3..0 let the external, thermal, local-high and local-low alarms drive the pin; hold-off is bit 4.
// - routing reaches the alarm pin only while the alarm output function is enabled.
// - a fixed span code overrides the auto-range detector for that group.
// - codes with bit 2 clear follow the detector; 100..111 pick -10..0, -5..0, 0..10 and 0..5 V.
// - group A span sits in bits 2..0 of the first span register, read/write, reset zero.
// - group B span sits in bits 6..4 of the first span register, read/write, reset zero.
// - group C span sits in bits 2..0 of the second span register, read/write, reset zero.
// - group D span sits in bits 6..4 of the second span register, read/write, reset zero.
// - each result low byte returns bits 7..0 of the 12-bit straight binary result and is read-only.
// - result registers occupy 0x20 to 0x49 and reset to zero.
// - reserved bits are left zero by software and reset to zero by the device.
// - an alarm rises only after the configured number of consecutive out-of-range conversions.
// - with hold-off clear, a status read clears all bits but those a same-cycle conversion sets; persisting conditions set again after the next conversion.
module ards_regs (
   // clock and reset
   input  wire logic                                       sys_clk,
   input  wire logic                                       rst_n,
   // register port
   input  wire logic [6:0]                                 reg_addr,
   input  wire logic                                       reg_wr,
   input  wire logic                                       reg_rd,
   input  wire logic [7:0]                                 reg_wdata,
   output logic      [7:0]                                 reg_rdata,
   output logic                                            reg_rvalid,
   // conversion results
   input  wire logic                                       result_wr,
   input  wire logic [4:0]                                 result_chan,
   input  wire logic [11:0]                                result_data,
   // alarm sources
   input  wire logic                                       conv_done,
   input  wire ards_pkg::ards_alarm_t                      alarm_cond,
   input  wire logic [ards_pkg::RUN_COUNT_W-1:0]           alarm_consec_n,
   input  wire logic                                       alarm_status_rd,
   input  wire logic                                       alarm_out_enable,
   output logic      [ards_pkg::ALARM_SOURCES-1:0]         alarm_status,
   output logic                                            alarm_hold_off,
   output logic                                            alarm_output_pin,
   // dac spans
   input  wire ards_pkg::ards_span_t [ards_pkg::DAC_GROUPS-1:0] auto_span,
   output logic      [ards_pkg::DAC_GROUPS-1:0][2:0]       span_effective
);

   logic [ards_pkg::ALARM_SOURCES-1:0] cond_vec;
   logic [ards_pkg::ALARM_SOURCES-1:0] routes;
   ards_pkg::ards_state_t              state;
   ards_pkg::ards_state_t              next_state;

   // fixed code wins, otherwise the detector's pick
   function automatic logic [2:0] span_pick(input logic [2:0] code, input ards_pkg::ards_span_t det);
      span_pick = code[ards_pkg::SPAN_FIXED_BIT] ? code : det;
   endfunction

   function automatic logic in_results(input logic [6:0] a);
      in_results = (a >= ards_pkg::ADDR_RESULT_FIRST) && (a <= ards_pkg::ADDR_RESULT_LAST);
   endfunction

   assign cond_vec = alarm_cond;
   assign routes   = state.routing[ards_pkg::ROUTE_EXT_BIT:ards_pkg::ROUTE_LOW_BIT];

   always_comb begin
      logic [6:0]                         idx;
      logic [ards_pkg::RUN_COUNT_W-1:0]   need;
      logic [ards_pkg::ALARM_SOURCES-1:0] qual;
      logic                               hold_off;
      next_state = state;
      idx        = 7'h00;
      need       = alarm_consec_n;
      qual       = '0;
      hold_off   = state.routing[ards_pkg::HOLD_OFF_BIT];
      // zero would mean no filtering at all; treat it as one
      if (need == '0) begin
         need = {{(ards_pkg::RUN_COUNT_W-1){1'b0}}, 1'b1};
      end

      // register writes; reserved bits are stored as written
      if (reg_wr) begin
         case (reg_addr)
            ards_pkg::ADDR_ALARM_ROUTING: next_state.routing = reg_wdata;
            ards_pkg::ADDR_SPAN_AB:       next_state.span_ab = reg_wdata;
            ards_pkg::ADDR_SPAN_CD:       next_state.span_cd = reg_wdata;
            default: ;
         endcase
      end

      // results are fed by the converter only, never by host writes
      if (result_wr && (result_chan < 5'(ards_pkg::RESULT_CHANNELS))) begin
         next_state.result_low[result_chan] = result_data[7:0];
      end

      // consecutive out-of-range filter, saturating
      for (int i = 0; i < ards_pkg::ALARM_SOURCES; i++) begin
         if (conv_done) begin
            if (!cond_vec[i]) begin
               next_state.run_cnt[i] = '0;
            end else if (state.run_cnt[i] != '1) begin
               next_state.run_cnt[i] = state.run_cnt[i] + 1'b1;
            end
         end
         qual[i] = conv_done && (next_state.run_cnt[i] >= need);
      end

      // status: in latched mode a read clears, a qualifying conversion sets, set wins
      for (int i = 0; i < ards_pkg::ALARM_SOURCES; i++) begin
         if (hold_off) begin
            if (conv_done) begin
               next_state.status[i] = qual[i];
            end
         end else begin
            if (alarm_status_rd) begin
               next_state.status[i] = 1'b0;
            end
            if (qual[i]) begin
               next_state.status[i] = 1'b1;
            end
         end
      end

      next_state.pin = alarm_out_enable && |(state.status & routes);

      next_state.span_eff[0] = span_pick(state.span_ab[ards_pkg::SPAN_LO_LSB +: ards_pkg::SPAN_W], auto_span[0]);
      next_state.span_eff[1] = span_pick(state.span_ab[ards_pkg::SPAN_HI_LSB +: ards_pkg::SPAN_W], auto_span[1]);
      next_state.span_eff[2] = span_pick(state.span_cd[ards_pkg::SPAN_LO_LSB +: ards_pkg::SPAN_W], auto_span[2]);
      next_state.span_eff[3] = span_pick(state.span_cd[ards_pkg::SPAN_HI_LSB +: ards_pkg::SPAN_W], auto_span[3]);

      // read path, one cycle latency; unmapped and high result bytes read zero
      next_state.rvalid = reg_rd;
      next_state.rdata  = ards_pkg::RESET_BYTE;
      if (reg_rd) begin
         case (reg_addr)
            ards_pkg::ADDR_ALARM_ROUTING: next_state.rdata = state.routing;
            ards_pkg::ADDR_SPAN_AB:       next_state.rdata = state.span_ab;
            ards_pkg::ADDR_SPAN_CD:       next_state.rdata = state.span_cd;
            default: begin
               if (in_results(reg_addr)) begin
                  idx = reg_addr - ards_pkg::ADDR_RESULT_FIRST;
                  if (!idx[0]) begin
                     next_state.rdata = state.result_low[idx[5:1]];
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign reg_rdata        = state.rdata;
   assign reg_rvalid       = state.rvalid;
   assign alarm_status     = state.status;
   assign alarm_hold_off   = state.routing[ards_pkg::HOLD_OFF_BIT];
   assign alarm_output_pin = state.pin;
   assign span_effective   = state.span_eff;

   pin_gated_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !alarm_out_enable |=> !alarm_output_pin)
      else $error("alarm pin active while output function disabled");

   pin_route_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      alarm_out_enable && |(alarm_status & routes) |=> alarm_output_pin)
      else $error("routed alarm did not reach the pin");

   unlatched_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      alarm_hold_off && !reg_wr && conv_done && (cond_vec == '0) |=> (alarm_status == '0))
      else $error("unlatched alarm stayed set after condition cleared");

   latched_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !alarm_hold_off && !reg_wr && !alarm_status_rd |=> ((alarm_status & $past(alarm_status)) == $past(alarm_status)))
      else $error("latched alarm dropped without a status read");

   read_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !alarm_hold_off && !reg_wr && alarm_status_rd && !conv_done |=> (alarm_status == '0))
      else $error("status read did not clear alarm bits");

   alarm_filter_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !conv_done |=> ((alarm_status & ~$past(alarm_status)) == '0))
      else $error("alarm rose without a conversion");

   span_fixed_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      state.span_ab[ards_pkg::SPAN_FIXED_BIT] ##1 $stable(state.span_ab)
      |-> span_effective[0] == $past(state.span_ab[2:0]))
      else $error("fixed span for group A not applied");

   span_auto_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !state.span_cd[ards_pkg::SPAN_HI_LSB + ards_pkg::SPAN_FIXED_BIT] |=> span_effective[3] == $past(auto_span[3]))
      else $error("group D did not follow the detector");

   result_ro_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      reg_wr && in_results(reg_addr) && !result_wr |=> $stable(state.result_low))
      else $error("host write altered a result register");

   // the fixed-span checks for groups B to D mirror the group A one
   span_b_fixed_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      state.span_ab[ards_pkg::SPAN_HI_LSB + ards_pkg::SPAN_FIXED_BIT] ##1 $stable(state.span_ab)
      |-> span_effective[1] == $past(state.span_ab[6:4]))
      else $error("fixed span for group B not applied");

   span_c_fixed_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      state.span_cd[ards_pkg::SPAN_FIXED_BIT] ##1 $stable(state.span_cd)
      |-> span_effective[2] == $past(state.span_cd[2:0]))
      else $error("fixed span for group C not applied");

   span_d_fixed_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      state.span_cd[ards_pkg::SPAN_HI_LSB + ards_pkg::SPAN_FIXED_BIT] ##1 $stable(state.span_cd)
      |-> span_effective[3] == $past(state.span_cd[6:4]))
      else $error("fixed span for group D not applied");

   // high result bytes are not kept, so they must read back as zero
   high_byte_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      reg_rd && in_results(reg_addr) && reg_addr[0] |=> reg_rdata == ards_pkg::RESET_BYTE)
      else $error("high result byte read nonzero");

   read_answer_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      reg_rd |=> reg_rvalid)
      else $error("read strobe got no answer");

   idle_rdata_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !reg_rd |=> !reg_rvalid && (reg_rdata == ards_pkg::RESET_BYTE))
      else $error("read data shown without a read");

   route_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      reg_rd && (reg_addr == ards_pkg::ADDR_ALARM_ROUTING) |=> reg_rdata == $past(state.routing))
      else $error("routing register read back wrong");

   pin_unrouted_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !(|(alarm_status & routes)) |=> !alarm_output_pin)
      else $error("alarm pin active with no routed alarm");

endmodule

/* rtl/ards_pkg.sv */
package ards_pkg;

   // register offsets
   localparam logic [6:0] ADDR_ALARM_ROUTING = 7'h1D;
   localparam logic [6:0] ADDR_SPAN_AB       = 7'h1E;
   localparam logic [6:0] ADDR_SPAN_CD       = 7'h1F;
   localparam logic [6:0] ADDR_RESULT_FIRST  = 7'h20;
   localparam logic [6:0] ADDR_RESULT_LAST   = 7'h49;

   // reset values
   localparam logic [7:0] RESET_BYTE = 8'h00;

   // routing register fields
   localparam int ROUTE_LOW_BIT    = 0;
   localparam int ROUTE_HIGH_BIT   = 1;
   localparam int ROUTE_THERM_BIT  = 2;
   localparam int ROUTE_EXT_BIT    = 3;
   localparam int HOLD_OFF_BIT     = 4;

   // span register fields
   localparam int SPAN_LO_LSB      = 0;
   localparam int SPAN_HI_LSB      = 4;
   localparam int SPAN_W           = 3;
   localparam int SPAN_FIXED_BIT   = 2;

   // alarm sources and result channels
   localparam int ALARM_SOURCES    = 4;
   localparam int RESULT_CHANNELS  = 21;
   localparam int RUN_COUNT_W      = 4;
   localparam int DAC_GROUPS       = 4;

   typedef enum logic [2:0] {
      ARDS_SPAN_AUTO  = 3'h0,
      ARDS_SPAN_NEG10 = 3'h4,
      ARDS_SPAN_NEG5  = 3'h5,
      ARDS_SPAN_POS10 = 3'h6,
      ARDS_SPAN_POS5  = 3'h7
   } ards_span_t;

   // raw out-of-range conditions, one bit per source
   typedef struct packed {
      logic ext_alarm;
      logic thermal;
      logic local_temp_high;
      logic local_temp_low;
   } ards_alarm_t;

   typedef struct packed {
      logic [7:0]                                  routing;
      logic [7:0]                                  span_ab;
      logic [7:0]                                  span_cd;
      logic [RESULT_CHANNELS-1:0][7:0]             result_low;
      logic [ALARM_SOURCES-1:0][RUN_COUNT_W-1:0]   run_cnt;
      logic [ALARM_SOURCES-1:0]                    status;
      logic                                        pin;
      logic [DAC_GROUPS-1:0][SPAN_W-1:0]           span_eff;
      logic [7:0]                                  rdata;
      logic                                        rvalid;
   } ards_state_t;

endpackage

/* verification/ards_host.sv */
`timescale 1ns/10ps
module ards_host (
   // register port toward the device
   input  wire logic       sys_clk,
   output logic      [6:0] reg_addr,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [7:0] reg_wdata
);
   initial begin
      reg_addr = 7'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
   end
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_wdata = d & ((a == ards_pkg::ADDR_ALARM_ROUTING) ? 8'h1F : 8'h77);
      reg_wr = 1'b1;
      @(negedge sys_clk);
      reg_wr = 1'b0;
      reg_wdata = ~reg_wdata;
   endtask
   task automatic rd(input logic [6:0] a);
      @(negedge sys_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge sys_clk);
      reg_rd = 1'b0;
   endtask
endmodule

/* verification/ards_regs_tb.sv */
`timescale 1ns/10ps
module ards_regs_tb;
   logic                           sys_clk, rst_n, reg_wr, reg_rd, reg_rvalid, result_wr, conv_done;
   logic                           alarm_status_rd, alarm_out_enable, alarm_hold_off, alarm_output_pin;
   logic [6:0]                     reg_addr;
   logic [7:0]                     reg_wdata, reg_rdata;
   logic [4:0]                     result_chan;
   logic [11:0]                    result_data, res;
   logic [3:0]                     alarm_consec_n, alarm_status;
   ards_pkg::ards_alarm_t          alarm_cond;
   ards_pkg::ards_span_t [3:0]     auto_span;
   logic [3:0][2:0]                span_effective;
   logic [2:0]                     c;
   logic [7:0]                     exp_q[$];
   int                             bad_count, n_tests, i;

   ards_host ards_host_inst (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata));
   ards_regs ards_regs_inst (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .result_wr(result_wr), .result_chan(result_chan), .result_data(result_data), .conv_done(conv_done),
      .alarm_cond(alarm_cond), .alarm_consec_n(alarm_consec_n), .alarm_status_rd(alarm_status_rd),
      .alarm_out_enable(alarm_out_enable), .alarm_status(alarm_status), .alarm_hold_off(alarm_hold_off),
      .alarm_output_pin(alarm_output_pin), .auto_span(auto_span), .span_effective(span_effective));

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      ards_host_inst.rd(a);
   endtask
   task automatic conv(input logic [3:0] cond);
      @(negedge sys_clk);
      alarm_cond = ards_pkg::ards_alarm_t'(cond);
      conv_done = 1'b1;
      @(negedge sys_clk);
      conv_done = 1'b0;
   endtask
   task automatic status_read();
      @(negedge sys_clk);
      alarm_status_rd = 1'b1;
      @(negedge sys_clk);
      alarm_status_rd = 1'b0;
   endtask
   function automatic logic [7:0] span_exp(input logic [2:0] code, input int g);
      return {5'h00, (code[2] ? code : 3'(auto_span[g]))};
   endfunction
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // read answers retire the oldest noted expectation
   always @(negedge sys_clk) begin
      if (reg_rvalid === 1'b1) begin
         if (exp_q.size() > 0)
            check("read data", reg_rdata, exp_q.pop_front());
         else begin
            bad_count++;
            $display("ERROR read answer expected none seen %h", reg_rdata);
         end
      end
   end

   initial begin
      void'($urandom(91543));
      {rst_n, result_wr, conv_done, alarm_status_rd} = 4'h0;
      {result_chan, result_data, alarm_cond} = '0;
      alarm_consec_n = 4'h2;
      alarm_out_enable = 1'b1;
      for (i = 0; i < 4; i++)
         auto_span[i] = ards_pkg::ards_span_t'(3'h4 | 3'($urandom % 4));
      repeat (10) @(negedge sys_clk);
      rst_n = 1'b1;
      repeat (2) @(negedge sys_clk);
      for (i = 0; i < 4; i++)
         check("span after reset", {5'h00, span_effective[i]}, span_exp(3'h0, i));
      rd(ards_pkg::ADDR_ALARM_ROUTING, 8'h00);
      rd(ards_pkg::ADDR_SPAN_AB, 8'h00);
      rd(ards_pkg::ADDR_SPAN_CD, 8'h00);
      rd(ards_pkg::ADDR_RESULT_FIRST, 8'h00);
      for (i = 0; i < 8; i++) begin
         c = 3'(i);
         ards_host_inst.wr(ards_pkg::ADDR_SPAN_AB, {1'b0, c, 1'b0, ~c});
         ards_host_inst.wr(ards_pkg::ADDR_SPAN_CD, {1'b0, ~c, 1'b0, c});
         rd(ards_pkg::ADDR_SPAN_AB, {1'b0, c, 1'b0, ~c});
         rd(ards_pkg::ADDR_SPAN_CD, {1'b0, ~c, 1'b0, c});
         check("span a", {5'h00, span_effective[0]}, span_exp(~c, 0));
         check("span b", {5'h00, span_effective[1]}, span_exp(c, 1));
         check("span c", {5'h00, span_effective[2]}, span_exp(c, 2));
         check("span d", {5'h00, span_effective[3]}, span_exp(~c, 3));
      end
      // last channel sits at the top of the result span
      res = 12'($urandom);
      @(negedge sys_clk);
      {result_wr, result_chan, result_data} = {1'b1, 5'd20, res};
      @(negedge sys_clk);
      result_wr = 1'b0;
      ards_host_inst.wr(7'h48, ~res[7:0]);
      rd(7'h48, res[7:0]);
      rd(ards_pkg::ADDR_RESULT_LAST, 8'h00);
      rd(7'h4A, 8'h00);
      ards_host_inst.wr(ards_pkg::ADDR_ALARM_ROUTING, 8'hEC);
      rd(ards_pkg::ADDR_ALARM_ROUTING, 8'h0C);
      conv(4'h8);
      conv(4'h0);
      check("short excursion", {4'h0, alarm_status}, 8'h00);
      conv(4'h8);
      conv(4'h8);
      check("latched set", {4'h0, alarm_status}, 8'h08);
      @(negedge sys_clk);
      check("routed pin", {7'h00, alarm_output_pin}, 8'h01);
      conv(4'h0);
      check("latched hold", {4'h0, alarm_status}, 8'h08);
      status_read();
      check("read clears", {4'h0, alarm_status}, 8'h00);
      alarm_out_enable = 1'b0;
      conv(4'h8);
      conv(4'h8);
      repeat (2) @(negedge sys_clk);
      check("disabled pin", {7'h00, alarm_output_pin}, 8'h00);
      ards_host_inst.wr(ards_pkg::ADDR_ALARM_ROUTING, 8'h1F);
      conv(4'h4);
      conv(4'h4);
      check("unlatched set", {3'h0, alarm_hold_off, alarm_status}, 8'h14);
      status_read();
      check("read ignored", {4'h0, alarm_status}, 8'h04);
      conv(4'h0);
      check("unlatched clear", {4'h0, alarm_status}, 8'h00);
      for (i = 0; i < 10 && exp_q.size() > 0; i++)
         @(negedge sys_clk);
      if (exp_q.size() > 0) begin
         bad_count++;
         $display("ERROR read answers expected %0d seen 0", exp_q.size());
      end
      end_sim();
   end
endmodule
